// ===== hw/fcs_defs.svh
// Constants of the flash command sequencer: register map, command bytes,
// field positions and timing figures.
// Assumes a 32-bit register bus with a 12-bit byte address and a 25 MHz pclk.
`ifndef FCS_DEFS_SVH
`define FCS_DEFS_SVH

// ********************************
// Register map
// ********************************
`define FCS_ADDR_W        12
`define FCS_OFF_STATUS    12'h000
`define FCS_OFF_PROTECT   12'h004
`define FCS_OFF_SECURE    12'h008
`define FCS_WIN_BIT       11

// ********************************
// Fields
// ********************************
`define FCS_CF_HI         10
`define FCS_CF_LO         7
`define FCS_WIDX_HI       6
`define FCS_WIDX_LO       2
`define FCS_BLOCK_BIT     4
`define FCS_STAT_READY    0
`define FCS_SEC_BIT       0

// ********************************
// Command address fields and data bytes
// ********************************
`define FCS_CF_55         4'h5
`define FCS_CF_AA         4'hA
`define FCS_D_AA          8'hAA
`define FCS_D_55          8'h55
`define FCS_D_READ        8'hF0
`define FCS_D_PROG        8'hA0
`define FCS_D_IDQ         8'h90
`define FCS_D_IDSEL       8'h00
`define FCS_D_ERASE       8'h80
`define FCS_D_CHIP        8'h10
`define FCS_D_BLOCK       8'h30
`define FCS_D_PBP         8'h9A
`define FCS_D_PBE         8'h6A

// ********************************
// Array geometry and reset values
// ********************************
`define FCS_WORDS         32
`define FCS_BLOCKS        2
`define FCS_PAGE_WORDS    4
`define FCS_ERASED        32'hFFFFFFFF
`define FCS_CNT_W         16

// ********************************
// Timing
// ********************************
`define FCS_CLK_NS        40
`define FCS_OP_TIME_NS    20000
`define FCS_RST_WAIT_NS   2000000

`endif

// ===== hw/fcs_pkg.sv
// Types of the flash command sequencer: sequence states, operations, state.
// Assumes fcs_defs.svh is on the include path.
`include "fcs_defs.svh"

package fcs_pkg;

	typedef enum logic [3:0] {
		S_READ, S_A1, S_A2, S_PROG, S_E3, S_E4, S_E5, S_E6, S_ID, S_BUSY
	} fcs_seq_e;

	typedef enum logic [2:0] {
		OP_NONE, OP_PROG, OP_ERASE, OP_CHIP, OP_BLOCK, OP_PBP, OP_PBE
	} fcs_op_e;

	typedef logic [31:0] fcs_word_t;

	typedef struct packed {
		fcs_seq_e                           seq;
		fcs_op_e                            op;
		logic [`FCS_CNT_W-1:0]              busy_cnt;
		logic [`FCS_CNT_W-1:0]              rst_cnt;
		logic [2:0]                         page;
		logic [1:0]                         wptr;
		logic [`FCS_PAGE_WORDS-1:0][31:0]   pbuf;
		logic                               block_sel;
		logic [1:0]                         id_sel;
		logic [`FCS_BLOCKS-1:0]             prot;
		logic                               secure;
		fcs_word_t                          rdata;
		logic                               rerr;
		logic [`FCS_WORDS-1:0][31:0]        mem;
	} fcs_state_s;

endpackage : fcs_pkg

// ===== hw/fcs_flash_command_sequencer.sv
// Flash command sequencer with a small modelled array behind a bus slave.
// Assumes a single pclk domain and a register-bus master on the same clock.
//
// Overview of operation
// - One page program stays within one page
// - Programming only clears bits, erase sets them
// - Protected block is never altered by programming
// - Three command cycles, then page words in order
// - Chip erase skips protected blocks, all-protected no-op
// - Chip erase starts on sixth write cycle
// - Block erase sixth cycle picks block, protected skipped
// - Protect program seventh cycle sets one bit
// - Protect erase clears bits in groups of four
// - Secure protect erase wipes array then bits
// - Ready flag low while busy, high after
// - Only hardware reset aborts an automatic operation
// - Identification fourth cycle selects code for reads
// - Maker, device, macro and type codes offered
// - Identification accepts repeated code selections
// - Identification mode left only by read commands
// - Read and read/reset commands return to read
// - Read command discards a partial sequence, except while page words are taken
// - Mismatched cycle abandons sequence to read mode
// - New commands ignored during automatic operation
// - Reset aborts operation, array reads wait two milliseconds
//
// Local design decisions: register access over APB and the address map.
`timescale 1ns/100ps
`include "fcs_defs.svh"

module fcs_flash_command_sequencer
	import fcs_pkg::*;
#(
	parameter int unsigned      RST_WAIT_CYC = `FCS_RST_WAIT_NS / `FCS_CLK_NS,
	parameter logic [31:0]      MAKER_CODE   = 32'h0000005A, // Arbitrary value
	parameter logic [31:0]      DEVICE_CODE  = 32'h000000C3, // Arbitrary value
	parameter logic [31:0]      MACRO_CODE   = 32'h00000011, // Arbitrary value
	parameter logic [31:0]      FLASH_TYPE   = 32'h00000002  // Arbitrary value
)
(
	input  wire logic                       pclk,
	input  wire logic                       presetn,
	input  wire logic                       ce,
	input  wire logic                       psel,
	input  wire logic                       penable,
	input  wire logic                       pwrite,
	input  wire logic [`FCS_ADDR_W-1:0]     paddr,
	input  wire logic [31:0]                pwdata,
	output logic                            pready,
	output logic [31:0]                     prdata,
	output logic                            pslverr,
	output logic                            op_done_flag,
	output logic [`FCS_BLOCKS-1:0]          per_block_protect_bits
);

	// ********************************
	// Timing
	// ********************************
	localparam int unsigned OP_CYC =
		(`FCS_OP_TIME_NS + `FCS_CLK_NS - 1) / `FCS_CLK_NS;
	localparam logic [`FCS_CNT_W-1:0] OP_LOAD = `FCS_CNT_W'(OP_CYC - 1);
	localparam logic [`FCS_CNT_W-1:0] RST_LOAD = `FCS_CNT_W'(RST_WAIT_CYC);

	fcs_state_s st_reg;
	fcs_state_s st_next;

	logic                       acc_wr;
	logic                       flash_wr;
	logic                       setup_rd;
	logic [7:0]                 db;
	logic [3:0]                 cf;
	logic [4:0]                 widx;

	// ********************************
	// Helpers
	// ********************************
	function automatic logic unlock_ok(input logic [7:0] d,
		input logic [3:0] f, input logic [7:0] want_d,
		input logic [3:0] want_f);
		unlock_ok = (d == want_d) && (f == want_f);
	endfunction : unlock_ok

	function automatic fcs_word_t id_code(input logic [1:0] sel);
		case (sel)
			2'h0: id_code = MAKER_CODE;
			2'h1: id_code = DEVICE_CODE;
			2'h2: id_code = MACRO_CODE;
			default: id_code = FLASH_TYPE;
		endcase
	endfunction : id_code

	assign acc_wr   = psel & penable & pwrite;
	assign flash_wr = acc_wr & paddr[`FCS_WIN_BIT];
	assign setup_rd = psel & ~penable & ~pwrite;
	assign db       = pwdata[7:0];
	assign cf       = paddr[`FCS_CF_HI:`FCS_CF_LO];
	assign widx     = paddr[`FCS_WIDX_HI:`FCS_WIDX_LO];

	assign pready   = 1'b1;
	assign prdata   = st_reg.rdata;
	assign pslverr  = st_reg.rerr;
	assign op_done_flag = (st_reg.seq != S_BUSY);
	assign per_block_protect_bits = st_reg.prot;

	// ********************************
	// Next state
	// ********************************
	always_comb
	begin
		st_next = st_reg;
		// Array reads stay refused until the array has recovered from reset
		if (st_reg.rst_cnt != '0)
			st_next.rst_cnt = st_reg.rst_cnt - 1'b1;

		// Read data is captured in the setup phase so prdata is a flop
		if (setup_rd)
		begin
			st_next.rerr  = 1'b0;
			st_next.rdata = '0;
			if (paddr[`FCS_WIN_BIT])
			begin
				if (st_reg.seq == S_BUSY || st_reg.rst_cnt != '0)
					st_next.rerr = 1'b1;
				else if (st_reg.seq == S_ID)
					st_next.rdata = id_code(st_reg.id_sel);
				else
					st_next.rdata = st_reg.mem[widx];
			end
			else
			begin
				case (paddr)
					`FCS_OFF_STATUS:
						st_next.rdata[`FCS_STAT_READY] = (st_reg.seq != S_BUSY);
					`FCS_OFF_PROTECT:
						st_next.rdata[`FCS_BLOCKS-1:0] = st_reg.prot;
					`FCS_OFF_SECURE:
						st_next.rdata[`FCS_SEC_BIT] = st_reg.secure;
					default:
						st_next.rerr = 1'b1;
				endcase
			end
		end

		if (acc_wr && !paddr[`FCS_WIN_BIT] && paddr == `FCS_OFF_SECURE)
			st_next.secure = pwdata[`FCS_SEC_BIT];

		if (st_reg.seq == S_BUSY)
		begin
			// Flash window writes have no effect here; only presetn can abort it
			if (st_reg.busy_cnt != '0)
				st_next.busy_cnt = st_reg.busy_cnt - 1'b1;
			else
			begin
				st_next.seq = S_READ;
				case (st_reg.op)
					OP_PROG:
						if (!st_reg.prot[st_reg.page[2]])
							for (int w = 0; w < `FCS_PAGE_WORDS; w++)
								st_next.mem[{st_reg.page, 2'(w)}] =
									st_reg.mem[{st_reg.page, 2'(w)}] &
									st_reg.pbuf[w];
					OP_CHIP:
						for (int i = 0; i < `FCS_WORDS; i++)
							if (!st_reg.prot[i / (`FCS_WORDS / `FCS_BLOCKS)])
								st_next.mem[i] = `FCS_ERASED;
					OP_BLOCK:
						for (int i = 0; i < `FCS_WORDS; i++)
							if (i / (`FCS_WORDS / `FCS_BLOCKS) ==
								int'(st_reg.block_sel))
								st_next.mem[i] = `FCS_ERASED;
					OP_PBP:
						st_next.prot[st_reg.block_sel] = 1'b1;
					OP_PBE:
					begin
						if (st_reg.secure)
							for (int i = 0; i < `FCS_WORDS; i++)
								st_next.mem[i] = `FCS_ERASED;
						// Both bits fall in one group of four
						st_next.prot = '0;
					end
					default:
						st_next.seq = S_READ;
				endcase
			end
		end
		else if (flash_wr)
		begin
			if (db == `FCS_D_READ && st_reg.seq != S_PROG)
				st_next.seq = S_READ;
			else
			begin
				case (st_reg.seq)
					S_READ:
						if (unlock_ok(db, cf, `FCS_D_AA, `FCS_CF_55))
							st_next.seq = S_A1;
					S_A1:
						if (unlock_ok(db, cf, `FCS_D_55, `FCS_CF_AA))
							st_next.seq = S_A2;
						else
							st_next.seq = S_READ;
					S_A2:
					begin
						st_next.seq = S_READ;
						st_next.wptr = '0;
						if (cf == `FCS_CF_55)
						begin
							case (db)
								`FCS_D_PROG:
									st_next.seq = S_PROG;
								`FCS_D_IDQ:
									st_next.seq = S_ID;
								`FCS_D_ERASE:
								begin
									st_next.seq = S_E3;
									st_next.op = OP_ERASE;
								end
								`FCS_D_PBP:
								begin
									st_next.seq = S_E3;
									st_next.op = OP_PBP;
								end
								`FCS_D_PBE:
								begin
									st_next.seq = S_E3;
									st_next.op = OP_PBE;
								end
								default:
									st_next.seq = S_READ;
							endcase
						end
					end
					S_PROG:
					begin
						// Page is fixed by the first word; later addresses
						// cannot move the write into another page
						if (st_reg.wptr == '0)
							st_next.page = widx[4:2];
						st_next.pbuf[st_reg.wptr] = pwdata;
						st_next.wptr = st_reg.wptr + 1'b1;
						if (st_reg.wptr == 2'(`FCS_PAGE_WORDS - 1))
						begin
							st_next.seq = S_BUSY;
							st_next.op = OP_PROG;
							st_next.busy_cnt = OP_LOAD;
						end
					end
					S_E3:
						if (unlock_ok(db, cf, `FCS_D_AA, `FCS_CF_55))
							st_next.seq = S_E4;
						else
							st_next.seq = S_READ;
					S_E4:
						if (unlock_ok(db, cf, `FCS_D_55, `FCS_CF_AA))
							st_next.seq = S_E5;
						else
							st_next.seq = S_READ;
					S_E5:
					begin
						st_next.seq = S_READ;
						st_next.block_sel = widx[`FCS_BLOCK_BIT];
						if (st_reg.op == OP_ERASE)
						begin
							if (unlock_ok(db, cf, `FCS_D_CHIP, `FCS_CF_55)
								&& !(&st_reg.prot))
							begin
								st_next.seq = S_BUSY;
								st_next.op = OP_CHIP;
								st_next.busy_cnt = OP_LOAD;
							end
							else if (db == `FCS_D_BLOCK &&
								!st_reg.prot[widx[`FCS_BLOCK_BIT]])
							begin
								st_next.seq = S_BUSY;
								st_next.op = OP_BLOCK;
								st_next.busy_cnt = OP_LOAD;
							end
						end
						else if (cf == `FCS_CF_55 &&
							((st_reg.op == OP_PBP && db == `FCS_D_PBP) ||
							(st_reg.op == OP_PBE && db == `FCS_D_PBE)))
							st_next.seq = S_E6;
					end
					S_E6:
					begin
						st_next.seq = S_READ;
						if ((st_reg.op == OP_PBP && db == `FCS_D_PBP) ||
							(st_reg.op == OP_PBE && db == `FCS_D_PBE))
						begin
							st_next.seq = S_BUSY;
							st_next.block_sel = widx[`FCS_BLOCK_BIT];
							st_next.busy_cnt = OP_LOAD;
						end
					end
					S_ID:
						if (db == `FCS_D_IDSEL)
							st_next.id_sel = widx[1:0];
					default:
						st_next.seq = S_READ;
				endcase
			end
		end
	end

	// ********************************
	// State register
	// ********************************
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			st_reg         <= '0;
			st_reg.mem     <= '1;
			st_reg.rst_cnt <= RST_LOAD;
		end
		else if (ce)
			st_reg <= st_next;
	end

	// ********************************
	// Checks
	// ********************************
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	sequence s_last_word;
		ce && st_reg.seq == S_PROG && flash_wr &&
		pwdata[7:0] != `FCS_D_READ &&
		st_reg.wptr == 2'(`FCS_PAGE_WORDS - 1);
	endsequence

	sequence s_op_end;
		ce && st_reg.seq == S_BUSY && st_reg.busy_cnt == '0;
	endsequence

	a_ready_low_busy: assert property (
		st_reg.seq == S_BUSY |-> !op_done_flag && (!setup_rd ||
		paddr != `FCS_OFF_STATUS || !st_next.rdata[`FCS_STAT_READY]))
		else $error("ready flag high during operation");

	a_busy_ends_read: assert property (
		s_op_end |=> st_reg.seq == S_READ && op_done_flag)
		else $error("operation did not end in read mode");

	a_no_cancel: assert property (
		ce && st_reg.seq == S_BUSY && st_reg.busy_cnt != '0 |=>
		st_reg.seq == S_BUSY && $past(st_reg.busy_cnt) - 1'b1 ==
		st_reg.busy_cnt)
		else $error("operation cancelled by bus");

	a_prog_start: assert property (
		s_last_word |=> st_reg.seq == S_BUSY && st_reg.op == OP_PROG &&
		st_reg.busy_cnt == OP_LOAD)
		else $error("page program did not start");

	a_prot_kept: assert property (
		s_op_end ##0 (st_reg.op == OP_PROG && st_reg.prot[st_reg.page[2]])
		|=> st_reg.mem == $past(st_reg.mem))
		else $error("protected block altered");

	a_prog_clears: assert property (
		ce && st_reg.op == OP_PROG && st_reg.seq == S_BUSY |=>
		(st_reg.mem & ~$past(st_reg.mem)) == '0)
		else $error("program set a bit");

	a_read_exits: assert property (
		ce && flash_wr && pwdata[7:0] == `FCS_D_READ &&
		st_reg.seq != S_BUSY &&
		st_reg.seq != S_PROG |=> st_reg.seq == S_READ)
		else $error("read command ignored");

	a_id_persists: assert property (
		ce && st_reg.seq == S_ID &&
		!(flash_wr && pwdata[7:0] == `FCS_D_READ)
		|=> st_reg.seq == S_ID)
		else $error("identification mode left");

	a_chip_allprot: assert property (
		ce && st_reg.seq == S_E5 && st_reg.op == OP_ERASE && flash_wr &&
		pwdata[7:0] == `FCS_D_CHIP && &st_reg.prot |=>
		st_reg.seq == S_READ)
		else $error("erase started with all blocks protected");

	a_busy_rd_err: assert property (
		ce && st_reg.seq == S_BUSY && setup_rd && paddr[`FCS_WIN_BIT] |=>
		pslverr && prdata == '0)
		else $error("array read during operation not flagged");

	a_page_fixed: assert property (
		ce && st_reg.seq == S_PROG && st_reg.wptr != '0 |=>
		st_reg.page == $past(st_reg.page))
		else $error("page moved within one program");

endmodule : fcs_flash_command_sequencer

// ===== test/fcs_host_model.sv
// Host model: a processor issuing single-word register-bus transfers.
// Assumes callers start a transfer right after a rising pclk edge.
`timescale 1ns/100ps

module fcs_host_model
(
	input  wire logic        pclk,
	input  wire logic        pready,
	input  wire logic [31:0] prdata,
	input  wire logic        pslverr,
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic [11:0]      paddr,
	output logic [31:0]      pwdata
);
	initial
	begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
	end

	// Released bus shows inverted values so stale data cannot pass
	task automatic xfer(input logic w, input logic [11:0] a,
		input logic [31:0] d, output logic [31:0] rd, output logic er);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		paddr <= ~a;
		pwdata <= ~d;
		@(posedge pclk);
	endtask : xfer
endmodule : fcs_host_model

// ===== test/tb_top.sv
// Bench for the flash command sequencer: command sequences go
// through the host model; array, flags and codes are checked.
// Assumes fcs_host_model and a 25 MHz pclk.
`timescale 1ns/100ps
`include "fcs_defs.svh"

module tb_top;
	localparam int          RW = 20;
	localparam logic [11:0] C5 = 12'hA80;
	localparam logic [11:0] CA = 12'hD00;
	localparam logic [11:0] W0 = 12'h800;
	localparam logic [11:0] B1 = 12'h840;
	localparam logic [31:0] FF = `FCS_ERASED;
	localparam int          OPC = `FCS_OP_TIME_NS / `FCS_CLK_NS;
	// Identification codes: arbitrary values
	localparam logic [3:0][31:0] IDC = {32'h44, 32'h33, 32'h22, 32'h11};
	logic        pclk, presetn, ce, psel, penable, pwrite;
	logic        pready, pslverr, op_done_flag;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [1:0]  per_block_protect_bits;
	int          failures, num_checks, cyc;

	fcs_flash_command_sequencer #(.RST_WAIT_CYC(RW), .MAKER_CODE(IDC[0]),
		.DEVICE_CODE(IDC[1]), .MACRO_CODE(IDC[2]), .FLASH_TYPE(IDC[3])) DUT
	(.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pready(pready), .prdata(prdata), .pslverr(pslverr),
		.op_done_flag(op_done_flag),
		.per_block_protect_bits(per_block_protect_bits));

	fcs_host_model HOST (.pclk(pclk), .pready(pready), .prdata(prdata),
		.pslverr(pslverr), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata));

	initial
		pclk = 1'b0;
	always #20 pclk = ~pclk;

	// ****************
	// Helpers
	// ****************
	task automatic stop_test;
		if (failures == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : stop_test

	task automatic cmp_w(input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e)
		begin
			failures++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
		end
	endtask : cmp_w

	task automatic cmp_b(input logic g, input logic e);
		cmp_w({31'h0, g}, {31'h0, e});
	endtask : cmp_b

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		HOST.xfer(1'b1, a, d, r, e);
	endtask : wr

	task automatic rdc(input logic [11:0] a, input logic [31:0] x,
		input logic xe);
		logic [31:0] r;
		logic        e;
		HOST.xfer(1'b0, a, 32'h0, r, e);
		cmp_w(r, x);
		cmp_b(e, xe);
	endtask : rdc

	task automatic pre(input logic [7:0] d);
		wr(C5, 32'hAA);
		wr(CA, 32'h55);
		wr(C5, {24'h0, d});
	endtask : pre

	task automatic seq6(input logic [7:0] d);
		pre(d);
		wr(C5, 32'hAA);
		wr(CA, 32'h55);
	endtask : seq6

	task automatic pb(input logic [7:0] d, input logic [11:0] a);
		seq6(d);
		wr(C5, {24'h0, d});
		wr(a, {24'h0, d});
	endtask : pb

	task automatic prot(input logic [1:0] x);
		cmp_w({30'h0, per_block_protect_bits}, {30'h0, x});
		rdc(12'h004, {30'h0, x}, 1'b0);
	endtask : prot

	// Probes a running operation, then waits for it with a bound
	task automatic busy;
		int n;
		n = 0;
		cmp_b(op_done_flag, 1'b0);
		rdc(12'h000, 32'h0, 1'b0);
		rdc(W0, 32'h0, 1'b1);
		wr(W0, 32'hF0);
		cmp_b(op_done_flag, 1'b0);
		while (op_done_flag !== 1'b1 && n < 600)
		begin
			@(posedge pclk);
			n++;
		end
		// Nine of the busy cycles go to the probes above
		cmp_w(n, OPC - 9);
		cmp_b(op_done_flag, 1'b1);
	endtask : busy

	task automatic prog(input logic [11:0] a, input logic [3:0][31:0] d);
		pre(8'hA0);
		for (int i = 0; i < 4; i++)
			wr(a + 12'(4 * i), d[i]);
		busy();
	endtask : prog

	// ****************
	// Scenarios
	// ****************
	task automatic t_reset;
		rdc(W0, 32'h0, 1'b1);
		rdc(12'h000, 32'h1, 1'b0);
		prot(2'b00);
		rdc(12'h00C, 32'h0, 1'b1);
		wr(12'h008, 32'h1);
		rdc(12'h008, 32'h1, 1'b0);
		wr(12'h008, 32'h0);
		repeat (RW) @(posedge pclk);
		rdc(W0, FF, 1'b0);
	endtask : t_reset

	task automatic t_prog;
		logic [3:0][31:0] d;
		d = {32'hC3C30F0F, 32'h0, FF, 32'h12345678};
		prog(12'h810, d);
		for (int i = 0; i < 4; i++)
			rdc(12'h810 + 12'(4 * i), d[i], 1'b0);
		rdc(12'h80C, FF, 1'b0);
		rdc(12'h820, FF, 1'b0);
	endtask : t_prog

	task automatic t_prot;
		prog(B1, {4{32'h0F0F0000}});
		pb(8'h9A, B1);
		busy();
		prot(2'b10);
		prog(12'h850, '0);
		rdc(12'h850, FF, 1'b0);
		seq6(8'h80);
		wr(B1, 32'h30);
		cmp_b(op_done_flag, 1'b1);
		rdc(B1, 32'h0F0F0000, 1'b0);
		seq6(8'h80);
		wr(C5, 32'h10);
		busy();
		rdc(12'h818, FF, 1'b0);
		rdc(B1, 32'h0F0F0000, 1'b0);
		pb(8'h6A, B1);
		busy();
		prot(2'b00);
		seq6(8'h80);
		wr(B1, 32'h30);
		busy();
		rdc(B1, FF, 1'b0);
	endtask : t_prot

	task automatic t_secure;
		prog(W0, '0);
		pb(8'h9A, W0);
		busy();
		pb(8'h9A, B1);
		busy();
		prot(2'b11);
		seq6(8'h80);
		wr(C5, 32'h10);
		cmp_b(op_done_flag, 1'b1);
		rdc(W0, 32'h0, 1'b0);
		wr(12'h008, 32'h1);
		pb(8'h6A, W0);
		busy();
		prot(2'b00);
		rdc(W0, FF, 1'b0);
		wr(12'h008, 32'h0);
	endtask : t_secure

	task automatic t_id;
		pre(8'h90);
		for (int i = 0; i < 4; i++)
		begin
			wr(W0 + 12'(4 * i), 32'h0);
			rdc(12'h87C, IDC[i], 1'b0);
		end
		repeat (50) @(posedge pclk);
		rdc(12'h820, IDC[3], 1'b0);
		pre(8'hF0);
		rdc(12'h820, FF, 1'b0);
		pre(8'h90);
		wr(W0 + 12'h4, 32'h0);
		rdc(W0, IDC[1], 1'b0);
		wr(W0, 32'hF0);
		rdc(W0, FF, 1'b0);
	endtask : t_id

	// Broken sequences must not end in identification mode
	task automatic t_abort;
		wr(C5, 32'hAA);
		wr(C5, 32'h55);
		wr(C5, 32'h90);
		wr(W0, 32'h0);
		rdc(W0, FF, 1'b0);
		wr(C5, 32'hAA);
		wr(W0, 32'hF0);
		wr(CA, 32'h55);
		wr(C5, 32'h90);
		wr(W0, 32'h0);
		rdc(W0, FF, 1'b0);
	endtask : t_abort

	task automatic t_rst;
		seq6(8'h80);
		wr(C5, 32'h10);
		cmp_b(op_done_flag, 1'b0);
		// Frozen clock enable must hold the operation past its length
		ce <= 1'b0;
		repeat (OPC + 20) @(posedge pclk);
		cmp_b(op_done_flag, 1'b0);
		ce <= 1'b1;
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		cmp_b(op_done_flag, 1'b1);
		rdc(W0, 32'h0, 1'b1);
		repeat (RW) @(posedge pclk);
		rdc(W0, FF, 1'b0);
	endtask : t_rst

	always @(posedge pclk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			failures++;
			stop_test();
		end
	end

	initial
	begin
		presetn = 1'b0;
		ce = 1'b1;
		failures = 0;
		num_checks = 0;
		cyc = 0;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_reset();
		t_prog();
		t_prot();
		t_secure();
		t_id();
		t_abort();
		t_rst();
		stop_test();
	end
endmodule : tb_top
